// ### shared/bank_timer_if.sv
// Purpose: carries load requests and ready flags between the core and one bank timer
// Assumes: one instance per bank
// Notes:   cycle values are the full spacing, the timer subtracts one itself
`timescale 1ns/1ps
interface bank_timer_if;
    import ddr2_timing_pkg::*;
    logic load_act;     // start a wait before the next activate
    logic load_pre;     // start a wait before the next precharge
    cyc_t act_cycles;   // spacing for the activate wait
    cyc_t pre_cycles;   // spacing for the precharge wait
    logic act_ok;       // activate may be taken now
    logic pre_ok;       // precharge may be taken now
    modport ctrl  (output load_act, load_pre, act_cycles, pre_cycles, input act_ok, pre_ok);
    modport timer (input load_act, load_pre, act_cycles, pre_cycles, output act_ok, pre_ok);
endinterface

// ### shared/ddr2_timing_map.svh
// Purpose: offsets, field positions, reset values and timing counts for the command timing core
// Assumes: 40 MHz command clock, period 25 ns
// Notes:   nanosecond figures are held in ps; cycle counts round up to whole clocks
`ifndef DDR2_TIMING_MAP_SVH
`define DDR2_TIMING_MAP_SVH

// clock period of ref_clk in ps
`define CLK_PERIOD_PS     25000
// nanosecond delays, in ps
`define T_RP_PS           15000
`define T_RTP_PS          7500
`define T_WTR_PS          7500
// delays fixed in clock cycles
`define XP_NCK            2
`define CCD_NCK           2
`define MRD_NCK           2
`define WTR_MIN_NCK       2
`define BURST_NCK         2
// round-up conversion of a ps delay to clock cycles
`define CEIL_CYC(ps)      (((ps) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define RP_CYC            `CEIL_CYC(`T_RP_PS)
`define RTP_CYC           `CEIL_CYC(`T_RTP_PS)
`define WTR_CYC           ((`CEIL_CYC(`T_WTR_PS) > `WTR_MIN_NCK) ? `CEIL_CYC(`T_WTR_PS) : `WTR_MIN_NCK)
// mode register fields
`define MR_CL_LSB         4
`define MR_WR_LSB         9
`define EMR_AL_LSB        3
`define EMR_DQS_BIT       10
`define CL_MIN            3
// reset values: read latency 3, recovery 1, additive 0, differential strobe
`define MR_RST            14'h0030
`define EMR_RST           14'h0000
`define NUM_BANKS         4

`endif

// ### shared/ddr2_timing_pkg.sv
// Purpose: types shared by the command timing core and its bank timers
// Assumes: nothing beyond the map header
// Notes:   numbers live in ddr2_timing_map.svh
package ddr2_timing_pkg;

    // command codes presented on cmd_code
    typedef enum logic [2:0] {
        CMD_ACT  = 3'h0,
        CMD_RD   = 3'h1,
        CMD_RDA  = 3'h2,
        CMD_WR   = 3'h3,
        CMD_WRA  = 3'h4,
        CMD_PRE  = 3'h5,
        CMD_MRS  = 3'h6,
        CMD_EMRS = 3'h7
    } cmd_e;

    // power-down tracking, one-hot
    typedef enum logic [2:0] {
        PD_RUN  = 3'b001,
        PD_DOWN = 3'b010,
        PD_EXIT = 3'b100
    } pd_state_e;

    // width of every spacing counter
    typedef logic [5:0] cyc_t;

endpackage

// ### verification/ddr2_ctrl_model.sv
// Purpose: controller model that drives commands and pins into the timing core
// Assumes: tasks are entered just after a rising edge
// Notes:   acceptance is read at the falling edge, where it has settled
`timescale 1ns/1ps
module ddr2_ctrl_model import ddr2_timing_pkg::*; (
    input  wire logic   ref_clk,
    input  wire logic   cmd_accept,
    output logic        cke_pin,
    output logic        vref_ok_pin,
    output logic        cmd_valid,
    output cmd_e        cmd_code,
    output logic [1:0]  cmd_bank,
    output logic [13:0] cmd_addr,
    output logic        dq_timing_bad
);
    // quiet bus, reference not yet settled
    initial begin
        cke_pin       = 1'b0;
        vref_ok_pin   = 1'b0;
        cmd_valid     = 1'b0;
        cmd_code      = CMD_ACT;
        cmd_bank      = 2'h0;
        cmd_addr      = 14'h0000;
        dq_timing_bad = 1'b0;
    end
    // one command for one cycle; valid stays up so back-to-back needs no drop
    task automatic issue(input cmd_e c, input logic [1:0] b, input logic [13:0] a, input logic bad,
                         output logic acc);
        cmd_valid     = 1'b1;
        cmd_code      = c;
        cmd_bank      = b;
        cmd_addr      = a;
        dq_timing_bad = bad;
        @(negedge ref_clk);
        acc = cmd_accept;
        @(posedge ref_clk);
        #1;
    endtask
    // idle cycles; address inverted so a stale value is never mistaken for data
    task automatic idle(input int n);
        cmd_valid = 1'b0;
        cmd_addr  = ~cmd_addr;
        repeat (n) begin
            @(posedge ref_clk);
            #1;
        end
    endtask
    // the caller holds each level until the core reports it, at least four edges
    task automatic set_pins(input logic cke, input logic vref);
        cke_pin     = cke;
        vref_ok_pin = vref;
    endtask
endmodule

// ### verification/test_ddr2_command_timing_rules.sv
// Purpose: self-checking bench for the command timing core
// Assumes: 40 MHz clock, controller model on the command side
// Notes:   every refused spacing is followed by power-down and re-initialisation
`timescale 1ns/1ps
module test_ddr2_command_timing_rules import ddr2_timing_pkg::*; ;
    logic        ref_clk, rst, cke_pin, vref_ok_pin, cmd_valid, dq_timing_bad;
    cmd_e        cmd_code;
    logic [1:0]  cmd_bank;
    logic [13:0] cmd_addr;
    logic        cmd_accept, cke_active, in_powerdown, strobe_single_ended;
    logic        write_strobe_due, timing_error, read_data_suspect;
    logic        clk_en = 1'b1;
    int          bad_count = 0;
    int          checked = 0;
    // clk_en drops only in the freeze scenario
    ddr2_timing_core dut_u (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .cke_pin(cke_pin),
        .vref_ok_pin(vref_ok_pin), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_bank(cmd_bank),
        .cmd_addr(cmd_addr), .dq_timing_bad(dq_timing_bad), .cmd_accept(cmd_accept), .cke_active(cke_active),
        .in_powerdown(in_powerdown), .strobe_single_ended(strobe_single_ended),
        .write_strobe_due(write_strobe_due), .timing_error(timing_error), .read_data_suspect(read_data_suspect));
    ddr2_ctrl_model ctrl_u (.ref_clk(ref_clk), .cmd_accept(cmd_accept), .cke_pin(cke_pin),
        .vref_ok_pin(vref_ok_pin), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_bank(cmd_bank),
        .cmd_addr(cmd_addr), .dq_timing_bad(dq_timing_bad));
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic check_bit(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // bounded wait on a status flag: 1 selects cke_active, 0 in_powerdown
    task automatic wait_for(input int sel, input string what);
        int n;
        n = 0;
        while ((sel == 1 ? cke_active : in_powerdown) !== 1'b1 && n < 40) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check_bit(what, 1'b1, sel == 1 ? cke_active : in_powerdown);
    endtask
    // cycle Tm is the first with cke_active high; command goes at Tm+2
    task automatic exit_then(input cmd_e c);
        logic acc;
        wait_for(1, "clock enable seen");
        ctrl_u.idle(2);
        ctrl_u.issue(c, 2'h0, 14'h0030, 1'b0, acc);
        ctrl_u.idle(0);
        check_bit("command two cycles after exit", 1'b1, acc);
    endtask
    task automatic recover();
        ctrl_u.set_pins(1'b0, 1'b1);
        wait_for(0, "power-down entry");
        ctrl_u.set_pins(1'b1, 1'b1);
        exit_then(CMD_MRS);
        @(negedge ref_clk);
        check_bit("error cleared by reinit", 1'b0, timing_error);
        @(posedge ref_clk);
        #1;
    endtask
    // two commands to bank 0 gap cycles apart; refusal must raise the sticky error
    task automatic pair(input cmd_e a, input cmd_e b, input int gap, input logic ok);
        logic acc;
        ctrl_u.idle(8);
        ctrl_u.issue(a, 2'h0, 14'h0030, 1'b0, acc);
        if (gap > 1) begin
            ctrl_u.idle(gap - 1);
        end
        ctrl_u.issue(b, 2'h0, 14'h0030, 1'b0, acc);
        ctrl_u.idle(0);
        check_bit("second command taken", ok, acc);
        @(negedge ref_clk);
        check_bit("timing error", ~ok, timing_error);
        @(posedge ref_clk);
        #1;
        if (!ok) begin
            recover();
        end
    endtask
    // write strobe lands exactly read latency minus one after the write
    task automatic t_write_latency();
        logic acc;
        for (int cl = 4; cl >= 3; cl--) begin
            ctrl_u.idle(8);
            ctrl_u.issue(CMD_MRS, 2'h0, 14'(cl << 4), 1'b0, acc);
            ctrl_u.idle(2);
            ctrl_u.issue(CMD_WR, 2'h0, 14'h0030, 1'b0, acc);
            ctrl_u.idle(0);
            for (int k = 1; k <= cl; k++) begin
                @(negedge ref_clk);
                check_bit("write strobe", 1'(k == cl - 1), write_strobe_due);
            end
            @(posedge ref_clk);
            #1;
        end
    endtask
    // extended mode bit 10 set then cleared
    task automatic t_strobe();
        logic acc;
        for (int v = 1; v >= 0; v--) begin
            ctrl_u.idle(4);
            ctrl_u.issue(CMD_EMRS, 2'h0, 14'(v << 10), 1'b0, acc);
            ctrl_u.idle(0);
            @(negedge ref_clk);
            check_bit("single-ended strobe", 1'(v), strobe_single_ended);
            @(posedge ref_clk);
            #1;
        end
    endtask
    // a broken write marks bank 1, a clean rewrite clears the mark
    task automatic t_suspect();
        logic acc;
        for (int b = 1; b >= 0; b--) begin
            ctrl_u.idle(4);
            ctrl_u.issue(CMD_WR, 2'h1, 14'h0030, 1'(b), acc);
            ctrl_u.idle(5);
            ctrl_u.issue(CMD_RD, 2'h1, 14'h0030, 1'b0, acc);
            ctrl_u.idle(0);
            @(negedge ref_clk);
            check_bit("read data suspect", 1'(b), read_data_suspect);
            @(posedge ref_clk);
            #1;
        end
    endtask
    // clk_en low: a low clock-enable pin and a command both go unnoticed
    task automatic t_freeze();
        logic acc;
        ctrl_u.idle(4);
        clk_en = 1'b0;
        ctrl_u.set_pins(1'b0, 1'b1);
        ctrl_u.idle(6);
        ctrl_u.issue(CMD_RD, 2'h0, 14'h0030, 1'b0, acc);
        ctrl_u.idle(0);
        check_bit("command taken while frozen", 1'b0, acc);
        check_bit("clock enable while frozen", 1'b1, cke_active);
        check_bit("timing error while frozen", 1'b0, timing_error);
        ctrl_u.set_pins(1'b1, 1'b1);
        clk_en = 1'b1;
    endtask
    initial begin
        rst = 1'b1;
        repeat (11) @(posedge ref_clk);
        @(negedge ref_clk);
        check_bit("power-down at reset", 1'b1, in_powerdown);
        check_bit("error at reset", 1'b0, timing_error);
        check_bit("strobe mode at reset", 1'b0, strobe_single_ended);
        @(posedge ref_clk);
        #1;
        rst = 1'b0;
        ctrl_u.set_pins(1'b1, 1'b0);
        ctrl_u.idle(8);
        check_bit("enable before reference settles", 1'b0, cke_active);
        ctrl_u.set_pins(1'b1, 1'b1);
        exit_then(CMD_ACT);
        t_write_latency();
        t_strobe();
        t_suspect();
        t_freeze();
        pair(CMD_RD, CMD_RD, 2, 1'b1);
        pair(CMD_RD, CMD_RD, 1, 1'b0);
        pair(CMD_MRS, CMD_MRS, 2, 1'b1);
        pair(CMD_MRS, CMD_MRS, 1, 1'b0);
        pair(CMD_WR, CMD_RD, 6, 1'b1);
        pair(CMD_WR, CMD_RD, 5, 1'b0);
        pair(CMD_RD, CMD_PRE, 1, 1'b1);
        pair(CMD_WRA, CMD_ACT, 6, 1'b1);
        pair(CMD_WRA, CMD_ACT, 5, 1'b0);
        pair(CMD_RDA, CMD_ACT, 2, 1'b1);
        pair(CMD_RDA, CMD_ACT, 1, 1'b0);
        give_verdict();
    end
    // the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge ref_clk);
        bad_count++;
        give_verdict();
    end
endmodule

// ### verilog/bank_timer.sv
// Purpose: per-bank down-counters that hold off activate and precharge
// Assumes: loads come from accepted commands only
// Notes:   a new load never shortens a wait already running
`timescale 1ns/1ps
module bank_timer import ddr2_timing_pkg::*; (
    input wire logic    ref_clk,
    input wire logic    rst,
    input wire logic    clk_en,
    bank_timer_if.timer tif
);

    cyc_t act_cnt_reg;   // cycles left before activate
    cyc_t act_cnt_next;
    cyc_t pre_cnt_reg;   // cycles left before precharge
    cyc_t pre_cnt_next;

    // load with spacing minus one so that the command lands exactly on cycle N
    function automatic cyc_t step(input logic ld, input cyc_t cyc, input cyc_t cur);
        cyc_t dec;
        dec = (cur != 6'h00) ? cyc_t'(cur - 6'h01) : 6'h00;
        if (ld && (cyc_t'(cyc - 6'h01) > dec)) begin
            step = cyc_t'(cyc - 6'h01);
        end else begin
            step = dec;
        end
    endfunction

    // next counter values
    always_comb begin
        act_cnt_next = step(tif.load_act, tif.act_cycles, act_cnt_reg);
        pre_cnt_next = step(tif.load_pre, tif.pre_cycles, pre_cnt_reg);
    end

    // registers, frozen while clk_en is low
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            act_cnt_reg <= 6'h00;
            pre_cnt_reg <= 6'h00;
        end else if (clk_en) begin
            act_cnt_reg <= act_cnt_next;
            pre_cnt_reg <= pre_cnt_next;
        end
    end

    // ready once the counters reach zero
    assign tif.act_ok = (act_cnt_reg == 6'h00);
    assign tif.pre_ok = (pre_cnt_reg == 6'h00);

endmodule

// ### verilog/ddr2_timing_core.sv
// Purpose: command acceptance and spacing checks of the memory, as seen behind its pins
// Assumes: cke_pin and vref_ok_pin are asynchronous; commands are on ref_clk
// Notes:   an illegal command is refused and latches timing_error until re-initialisation
`timescale 1ns/1ps
`include "ddr2_timing_map.svh"

// Summary of operation
// - power-down exit at Tm, activate at Tm+2
// - nanosecond delays round up, counted in edges
// - extended mode bit 10 selects single-ended strobe
// - before reference settles, clock enable reads low
// - write latency is read latency minus one
module ddr2_timing_core import ddr2_timing_pkg::*; (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire logic        cke_pin,
    input  wire logic        vref_ok_pin,
    input  wire logic        cmd_valid,
    input  wire cmd_e        cmd_code,
    input  wire logic [1:0]  cmd_bank,
    input  wire logic [13:0] cmd_addr,
    input  wire logic        dq_timing_bad,
    output logic             cmd_accept,
    output logic             cke_active,
    output logic             in_powerdown,
    output logic             strobe_single_ended,
    output logic             write_strobe_due,
    output logic             timing_error,
    output logic             read_data_suspect
);

    localparam cyc_t RP_CYC  = cyc_t'(`RP_CYC);
    localparam cyc_t RTP_CYC = cyc_t'(`RTP_CYC);
    localparam cyc_t WTR_CYC = cyc_t'(`WTR_CYC);
    localparam cyc_t XP_CYC  = cyc_t'(`XP_NCK);
    localparam cyc_t CCD_CYC = cyc_t'(`CCD_NCK);
    localparam cyc_t MRD_CYC = cyc_t'(`MRD_NCK);
    localparam cyc_t BST_CYC = cyc_t'(`BURST_NCK);

    // true for read and write bursts
    function automatic logic is_column(input cmd_e c);
        is_column = (c == CMD_RD) || (c == CMD_RDA) || (c == CMD_WR) || (c == CMD_WRA);
    endfunction

    // true for the two write flavours
    function automatic logic is_write(input cmd_e c);
        is_write = (c == CMD_WR) || (c == CMD_WRA);
    endfunction

    // pin synchronisers and settled levels
    logic [2:0]  cke_sync_reg;     // three-stage chain for the clock-enable pin
    logic [2:0]  cke_sync_next;
    logic [2:0]  vref_sync_reg;    // three-stage chain for the reference-good pin
    logic [2:0]  vref_sync_next;
    logic        cke_level_reg;    // settled clock-enable level
    logic        cke_level_next;
    logic        vref_level_reg;   // settled reference-good level
    logic        vref_level_next;
    // power-down tracking
    pd_state_e   pd_state_reg;
    pd_state_e   pd_state_next;
    cyc_t        xp_cnt_reg;       // cycles left after power-down exit
    cyc_t        xp_cnt_next;
    // global spacing counters
    cyc_t        ccd_cnt_reg;      // column to column
    cyc_t        ccd_cnt_next;
    cyc_t        mrd_cnt_reg;      // mode set to mode set
    cyc_t        mrd_cnt_next;
    cyc_t        wtr_cnt_reg;      // write to read
    cyc_t        wtr_cnt_next;
    // mode registers
    logic [13:0] mode_reg;
    logic [13:0] mode_next;
    logic [13:0] extended_mode_reg;
    logic [13:0] extended_mode_next;
    // error and data-quality state
    logic        err_reg;
    logic        err_next;
    logic        pd_seen_reg;      // power-down seen since the error
    logic        pd_seen_next;
    logic [3:0]  suspect_reg;      // per-bank corrupted-write marks
    logic [3:0]  suspect_next;
    logic        rd_suspect_reg;
    logic        rd_suspect_next;
    logic [15:0] wr_pipe_reg;      // one bit per cycle since each accepted write
    logic [15:0] wr_pipe_next;
    logic        wstrobe_reg;
    logic        wstrobe_next;
    // combinational decode
    logic        cke_eff;          // clock enable as the core sees it
    logic        pd_ready;         // exit spacing has elapsed
    logic        legal;            // command meets every spacing
    logic        violation;        // valid command that breaks spacing
    logic [3:0]  act_ok;
    logic [3:0]  pre_ok;
    logic [3:0]  cl_eff;
    logic [3:0]  wl;               // write latency in cycles
    cyc_t        wr_cyc;           // programmed write recovery
    cyc_t        act_val;
    cyc_t        pre_val;
    logic        ld_act;
    logic        ld_pre;

    bank_timer_if bt_if [`NUM_BANKS] ();

    // one timer per bank, each loaded only by commands aimed at it
    genvar g;
    generate
        for (g = 0; g < `NUM_BANKS; g++) begin : g_bank
            assign bt_if[g].load_act   = ld_act && (cmd_bank == 2'(g));
            assign bt_if[g].load_pre   = ld_pre && (cmd_bank == 2'(g));
            assign bt_if[g].act_cycles = act_val;
            assign bt_if[g].pre_cycles = pre_val;
            assign act_ok[g]           = bt_if[g].act_ok;
            assign pre_ok[g]           = bt_if[g].pre_ok;
            bank_timer u_timer (
                .ref_clk (ref_clk),
                .rst     (rst),
                .clk_en  (clk_en),
                .tif     (bt_if[g])
            );
        end
    endgenerate

    // latencies from the mode registers; write latency one under read latency
    always_comb begin
        cl_eff = {1'b0, mode_reg[`MR_CL_LSB +: 3]};
        if (cl_eff < 4'(`CL_MIN)) begin
            cl_eff = 4'(`CL_MIN);
        end
        wl     = 4'(cl_eff + {1'b0, extended_mode_reg[`EMR_AL_LSB +: 3]} - 4'h1);
        wr_cyc = cyc_t'({3'b000, mode_reg[`MR_WR_LSB +: 3]} + 6'h01);
    end

    // settled levels; no reference means clock enable reads low
    assign cke_eff  = vref_level_reg && cke_level_reg;
    assign pd_ready = (pd_state_reg == PD_RUN) || ((pd_state_reg == PD_EXIT) && (xp_cnt_reg == 6'h00));

    // spacing check of the command on the bus
    always_comb begin
        unique case (cmd_code)
            CMD_ACT:           legal = act_ok[cmd_bank];
            CMD_PRE:           legal = pre_ok[cmd_bank];
            CMD_RD, CMD_RDA:   legal = (ccd_cnt_reg == 6'h00) && (wtr_cnt_reg == 6'h00);
            CMD_WR, CMD_WRA:   legal = (ccd_cnt_reg == 6'h00);
            CMD_MRS, CMD_EMRS: legal = (mrd_cnt_reg == 6'h00);
        endcase
    end

    // commands count only with valid inputs and clock enable high
    // a frozen core takes nothing and flags nothing, since its counters would not move
    assign violation  = clk_en && cmd_valid && cke_eff && !(pd_ready && legal);
    assign cmd_accept = clk_en && cmd_valid && cke_eff && pd_ready && legal;

    // bank timer loads, all from accepted commands
    always_comb begin
        ld_act  = cmd_accept && ((cmd_code == CMD_PRE) || (cmd_code == CMD_RDA) || (cmd_code == CMD_WRA));
        ld_pre  = cmd_accept && ((cmd_code == CMD_RD) || (cmd_code == CMD_WR));
        act_val = RP_CYC;
        pre_val = RTP_CYC;
        if (cmd_code == CMD_RDA) begin
            act_val = cyc_t'(RTP_CYC + RP_CYC);
        end else if (cmd_code == CMD_WRA) begin
            act_val = cyc_t'({2'b00, wl} + BST_CYC + wr_cyc + RP_CYC);
        end
        if (cmd_code == CMD_WR) begin
            pre_val = cyc_t'({2'b00, wl} + BST_CYC + wr_cyc);
        end
    end

    // synchronisers: a change counts once stages two and three agree
    always_comb begin
        cke_sync_next   = {cke_sync_reg[1:0], cke_pin};
        vref_sync_next  = {vref_sync_reg[1:0], vref_ok_pin};
        cke_level_next  = (cke_sync_reg[1] == cke_sync_reg[2]) ? cke_sync_reg[2] : cke_level_reg;
        vref_level_next = (vref_sync_reg[1] == vref_sync_reg[2]) ? vref_sync_reg[2] : vref_level_reg;
    end

    // power-down entry and exit; exit edge Tm blocks Tm and Tm+1
    always_comb begin
        pd_state_next = pd_state_reg;
        xp_cnt_next   = (xp_cnt_reg != 6'h00) ? cyc_t'(xp_cnt_reg - 6'h01) : 6'h00;
        unique case (pd_state_reg)
            PD_RUN: begin
                if (!cke_eff) pd_state_next = PD_DOWN;
            end
            PD_DOWN: begin
                if (cke_eff) begin
                    pd_state_next = PD_EXIT;
                    xp_cnt_next   = cyc_t'(XP_CYC - 6'h01);
                end
            end
            PD_EXIT: begin
                if (!cke_eff) pd_state_next = PD_DOWN;
                else if (xp_cnt_reg == 6'h00) pd_state_next = PD_RUN;
            end
            default: pd_state_next = PD_DOWN;  // illegal code: treat as powered down
        endcase
    end

    // global spacing counters
    always_comb begin
        ccd_cnt_next = (ccd_cnt_reg != 6'h00) ? cyc_t'(ccd_cnt_reg - 6'h01) : 6'h00;
        mrd_cnt_next = (mrd_cnt_reg != 6'h00) ? cyc_t'(mrd_cnt_reg - 6'h01) : 6'h00;
        wtr_cnt_next = (wtr_cnt_reg != 6'h00) ? cyc_t'(wtr_cnt_reg - 6'h01) : 6'h00;
        if (cmd_accept && is_column(cmd_code)) begin
            ccd_cnt_next = cyc_t'(CCD_CYC - 6'h01);
        end
        if (cmd_accept && ((cmd_code == CMD_MRS) || (cmd_code == CMD_EMRS))) begin
            mrd_cnt_next = cyc_t'(MRD_CYC - 6'h01);
        end
        if (cmd_accept && is_write(cmd_code)) begin
            // hold reads until the burst is in plus the write-to-read gap
            wtr_cnt_next = cyc_t'({2'b00, wl} + BST_CYC + WTR_CYC - 6'h01);
        end
    end

    // mode registers, error latch, corrupted-data marks, write strobe timing
    always_comb begin
        mode_next          = mode_reg;
        extended_mode_next = extended_mode_reg;
        if (cmd_accept && (cmd_code == CMD_MRS)) mode_next = cmd_addr;
        if (cmd_accept && (cmd_code == CMD_EMRS)) extended_mode_next = cmd_addr;
        // error clears only after power-down then a mode set; a new fault wins
        // a fresh violation asks for a fresh power-down before the clear
        pd_seen_next = (pd_seen_reg || (err_reg && (pd_state_reg == PD_DOWN))) &&
                       !(cmd_accept && (cmd_code == CMD_MRS)) && !violation;
        err_next     = violation || (err_reg && !(pd_seen_reg && cmd_accept && (cmd_code == CMD_MRS)));
        // a write with bad data timing marks the bank; a clean write clears it
        suspect_next = suspect_reg;
        if (cmd_accept && is_write(cmd_code)) begin
            suspect_next[cmd_bank] = dq_timing_bad;
        end
        rd_suspect_next = cmd_accept && !is_write(cmd_code) && is_column(cmd_code) && suspect_reg[cmd_bank];
        wr_pipe_next    = {wr_pipe_reg[14:0], cmd_accept && is_write(cmd_code)};
        wstrobe_next    = wr_pipe_reg[wl - 4'h2];
    end

    // state registers; asynchronous reset, frozen while clk_en is low
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cke_sync_reg      <= 3'h0;
            vref_sync_reg     <= 3'h0;
            cke_level_reg     <= 1'b0;
            vref_level_reg    <= 1'b0;
            pd_state_reg      <= PD_DOWN;
            xp_cnt_reg        <= 6'h00;
            ccd_cnt_reg       <= 6'h00;
            mrd_cnt_reg       <= 6'h00;
            wtr_cnt_reg       <= 6'h00;
            mode_reg          <= `MR_RST;
            extended_mode_reg <= `EMR_RST;
            err_reg           <= 1'b0;
            pd_seen_reg       <= 1'b0;
            suspect_reg       <= 4'h0;
            rd_suspect_reg    <= 1'b0;
            wr_pipe_reg       <= 16'h0000;
            wstrobe_reg       <= 1'b0;
        end else if (clk_en) begin
            cke_sync_reg      <= cke_sync_next;
            vref_sync_reg     <= vref_sync_next;
            cke_level_reg     <= cke_level_next;
            vref_level_reg    <= vref_level_next;
            pd_state_reg      <= pd_state_next;
            xp_cnt_reg        <= xp_cnt_next;
            ccd_cnt_reg       <= ccd_cnt_next;
            mrd_cnt_reg       <= mrd_cnt_next;
            wtr_cnt_reg       <= wtr_cnt_next;
            mode_reg          <= mode_next;
            extended_mode_reg <= extended_mode_next;
            err_reg           <= err_next;
            pd_seen_reg       <= pd_seen_next;
            suspect_reg       <= suspect_next;
            rd_suspect_reg    <= rd_suspect_next;
            wr_pipe_reg       <= wr_pipe_next;
            wstrobe_reg       <= wstrobe_next;
        end
    end

    // outputs
    assign cke_active          = cke_eff;
    assign in_powerdown        = (pd_state_reg == PD_DOWN);
    assign strobe_single_ended = extended_mode_reg[`EMR_DQS_BIT];
    assign write_strobe_due    = wstrobe_reg;
    assign timing_error        = err_reg;
    assign read_data_suspect   = rd_suspect_reg;

    // checks; assume clk_en held high while they matter
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst || !clk_en);

    a_exit_gap_block: assert property ((pd_state_reg == PD_DOWN) && cke_eff |-> !cmd_accept ##1 !cmd_accept)
        else $error("command taken within two cycles of power-down exit");
    a_exit_ready_two: assert property ((pd_state_reg == PD_DOWN) && cke_eff ##1 cke_eff ##1 cke_eff |-> pd_ready)
        else $error("exit spacing not over at Tm plus two");
    a_column_spacing: assert property (cmd_accept && is_column(cmd_code) |=> !(cmd_accept && is_column(cmd_code)))
        else $error("column commands taken back to back");
    a_strobe_mode_bit: assert property (cmd_accept && (cmd_code == CMD_EMRS) |=> strobe_single_ended == $past(cmd_addr[10]))
        else $error("strobe mode does not follow bit 10");
    a_vref_gate_low: assert property (!vref_level_reg |-> !cmd_accept && !cke_active ##1 !cmd_accept)
        else $error("input honoured before reference settled");
    a_write_lat_two: assert property (cmd_accept && is_write(cmd_code) && (wl == 4'h2) |-> ##1 !write_strobe_due ##1 write_strobe_due)
        else $error("write strobe not due two cycles after write");
    a_write_lat_three: assert property (cmd_accept && is_write(cmd_code) && (wl == 4'h3) ##1 !write_strobe_due |-> ##2 write_strobe_due)
        else $error("write strobe not due three cycles after write");
    a_error_latch: assert property (violation |=> timing_error [*2])
        else $error("illegal spacing did not latch the error");

endmodule
